/* File: include/jpt_pkg.sv */
// constants and types shared by the jog pulse-train output block
package jpt_pkg;
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned PULSE_HZ     = 100_000;
    localparam int unsigned HALF_CYC     = CLK_HZ / (2 * PULSE_HZ);
    localparam int unsigned HALF_W       = 8;
    localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_CYC - 1);

    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned WORD_W       = 16;
    localparam int unsigned POS_W        = 32;

    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_POS_LO = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_POS_HI = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATE  = 8'h14;

    // ctrl fields
    localparam int unsigned CTRL_MODE_BIT = 0;
    localparam logic        CTRL_MODE_RST = 1'b0;
    // status and mask fields
    localparam int unsigned EVT_W         = 2;
    localparam int unsigned EVT_ABN_BIT   = 0;
    localparam int unsigned EVT_STOP_BIT  = 1;
    localparam logic [EVT_W-1:0] STATUS_RST = 2'h0;
    localparam logic [EVT_W-1:0] MASK_RST   = 2'h0;
    localparam logic [POS_W-1:0] POS_RST    = 32'h0000_0000;

    typedef enum logic {
        MODE_PULSE_DIR,
        MODE_FWD_REV
    } jpt_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FWD,
        ST_REV
    } jpt_state_e;

    typedef struct packed {
        logic jog_fwd;
        logic jog_rev;
        logic fwd_limit;
        logic rev_limit;
    } jpt_switch_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } jpt_bus_req_s;
endpackage

/* File: rtl/jpt_pulse_gen.sv */
// square-wave generator for the pulse train, with a rising-edge tick
`timescale 1ns/1ps
`default_nettype none
module jpt_pulse_gen
    import jpt_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      level,
    output logic      rise_tick
);
    logic [HALF_W-1:0] cnt_q;
    logic              level_q;
    logic              tick_q;

    // dropping run forces the level low at once, so a stop leaves it low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
            tick_q  <= 1'b0;
        end else if (!run) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
            tick_q  <= 1'b0;
        end else if (cnt_q == HALF_LAST) begin
            cnt_q   <= '0;
            level_q <= ~level_q;
            tick_q  <= ~level_q;
        end else begin
            cnt_q   <= cnt_q + HALF_W'(1);
            tick_q  <= 1'b0;
        end
    end

    assign level     = level_q;
    assign rise_tick = tick_q;
endmodule
`default_nettype wire

/* File: rtl/jpt_top.sv */
// jog-driven pulse-train positioning output with register port
//
// Overview of operation
// - forward jog pressed alone with both limits high starts forward motion.
// - forward motion toggles the pulse train continuously.
// - in pulse-plus-direction mode direction is high in forward and stays high after.
// - in separate-train mode forward pulses go on the first output, second stays low.
// - each forward pulse increments the 32-bit position, kept as low and high words.
// - releasing forward jog ends forward motion.
// - at the end of motion the active pulse output stops and rests low.
// - with pulses stopped the position holds still.
// - forward limit going low stops forward motion like a normal jog stop.
// - a stop caused by a limit sets the abnormal-end flag.
// - reverse jog emits reverse pulses and decrements the position.
// - reverse limit going low in reverse stops motion and sets the abnormal-end flag.
`timescale 1ns/1ps
`default_nettype none
module jpt_top
    import jpt_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              fwd_limit_in,
    input  wire logic              rev_limit_in,
    input  wire logic              jog_fwd_in,
    input  wire logic              jog_rev_in,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [DATA_W-1:0]      reg_rdata,
    output logic                   pulse_out,
    output logic                   direction_out,
    output logic                   abnormal_end_flag,
    output logic                   irq
);
    // start check, used for both directions
    function automatic logic start_ok(input jpt_switch_s s,
                                      input logic        fwd);
        logic jog_ok;
        jog_ok = fwd ? (s.jog_fwd && !s.jog_rev)
                     : (s.jog_rev && !s.jog_fwd);
        return jog_ok && s.fwd_limit && s.rev_limit;
    endfunction

    logic         rst_meta_q;
    logic         rst_sync_q;
    logic         rst_sync_n;
    jpt_switch_s  sw;
    jpt_bus_req_s req;
    jpt_state_e   state_q;
    jpt_state_e   state_d;
    jpt_mode_e    mode_q;
    jpt_mode_e    run_mode_q;
    logic         dir_q;
    logic [POS_W-1:0]  pos_q;
    logic [WORD_W-1:0] hi_snap_q;
    logic [WORD_W-1:0] hi_wr_q;
    logic [EVT_W-1:0]  status_q;
    logic [EVT_W-1:0]  mask_q;
    logic [EVT_W-1:0]  evt;
    logic         stop_normal;
    logic         stop_limit;
    logic         moving;
    logic         lvl;
    logic         tick;
    logic [DATA_W-1:0] rdata_q;
    logic         pulse_q;
    logic         dirout_q;
    logic         abn_q;
    logic         irq_q;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_sync_n = rst_sync_q;

    // active level of inputs follows the switch wiring
    assign sw.jog_fwd   = jog_fwd_in;
    assign sw.jog_rev   = jog_rev_in;
    assign sw.fwd_limit = fwd_limit_in;
    assign sw.rev_limit = rev_limit_in;

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    assign moving = (state_q != ST_IDLE);

    // motion state
    always_comb begin
        state_d     = state_q;
        stop_normal = 1'b0;
        stop_limit  = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                // both jogs pressed or a limit open: no start
                if (start_ok(sw, 1'b1)) begin
                    state_d = ST_FWD;
                end else if (start_ok(sw, 1'b0)) begin
                    state_d = ST_REV;
                end
            end
            ST_FWD: begin
                if (!sw.fwd_limit) begin
                    state_d    = ST_IDLE;
                    stop_limit = 1'b1;
                end else if (!sw.jog_fwd) begin
                    state_d     = ST_IDLE;
                    stop_normal = 1'b1;
                end
            end
            ST_REV: begin
                if (!sw.rev_limit) begin
                    state_d    = ST_IDLE;
                    stop_limit = 1'b1;
                end else if (!sw.jog_rev) begin
                    state_d     = ST_IDLE;
                    stop_normal = 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // mode is frozen for the whole move so outputs never swap mid-train
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_mode_q <= MODE_PULSE_DIR;
            dir_q      <= 1'b0;
        end else if (state_q == ST_IDLE && state_d != ST_IDLE) begin
            run_mode_q <= mode_q;
            dir_q      <= (state_d == ST_FWD);
        end
    end

    jpt_pulse_gen u_pulse_gen (
        .clk       (clk),
        .rst_n     (rst_sync_n),
        .run       (moving && state_d == state_q),
        .level     (lvl),
        .rise_tick (tick)
    );

    // output pins
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pulse_q  <= 1'b0;
            dirout_q <= 1'b0;
        end else if (run_mode_q == MODE_PULSE_DIR) begin
            pulse_q  <= lvl;
            dirout_q <= dir_q;
        end else begin
            pulse_q  <= lvl && state_q == ST_FWD;
            dirout_q <= lvl && state_q == ST_REV;
        end
    end

    // position count; software preset only while idle
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pos_q <= POS_RST;
        end else if (tick && state_q == ST_FWD) begin
            pos_q <= pos_q + POS_W'(1);
        end else if (tick && state_q == ST_REV) begin
            pos_q <= pos_q - POS_W'(1);
        end else if (!moving && req.wr && req.addr == ADDR_POS_LO) begin
            pos_q <= {hi_wr_q, req.wdata[WORD_W-1:0]};
        end
        // no tick once stopped, so the count holds
    end

    // high word staged on write, snapshotted on low-word read
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hi_wr_q   <= '0;
            hi_snap_q <= '0;
        end else begin
            if (req.wr && req.addr == ADDR_POS_HI) begin
                hi_wr_q <= req.wdata[WORD_W-1:0];
            end
            if (req.rd && req.addr == ADDR_POS_LO) begin
                hi_snap_q <= pos_q[POS_W-1:WORD_W];
            end
        end
    end

    // control and mask registers
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_q <= jpt_mode_e'(CTRL_MODE_RST);
            mask_q <= MASK_RST;
        end else if (req.wr) begin
            if (req.addr == ADDR_CTRL) begin
                mode_q <= jpt_mode_e'(req.wdata[CTRL_MODE_BIT]);
            end
            if (req.addr == ADDR_MASK) begin
                mask_q <= req.wdata[EVT_W-1:0];
            end
        end
    end

    // sticky events, write one to clear, a new event beats the clear
    always_comb begin
        evt               = '0;
        evt[EVT_ABN_BIT]  = stop_limit;
        evt[EVT_STOP_BIT] = stop_normal || stop_limit;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            status_q <= STATUS_RST;
        end else begin
            for (int i = 0; i < EVT_W; i++) begin
                if (evt[i]) begin
                    status_q[i] <= 1'b1;
                end else if (req.wr && req.addr == ADDR_STATUS &&
                             req.wdata[i]) begin
                    status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            abn_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            abn_q <= status_q[EVT_ABN_BIT] || evt[EVT_ABN_BIT];
            irq_q <= |((status_q | evt) & mask_q);
        end
    end

    // read port: data in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= '0;
        end else if (!req.rd) begin
            rdata_q <= '0;
        end else begin
            unique case (req.addr)
                ADDR_CTRL:   rdata_q <= DATA_W'(mode_q);
                ADDR_STATUS: rdata_q <= DATA_W'(status_q);
                ADDR_MASK:   rdata_q <= DATA_W'(mask_q);
                ADDR_POS_LO: rdata_q <= DATA_W'(pos_q[WORD_W-1:0]);
                ADDR_POS_HI: rdata_q <= DATA_W'(hi_snap_q);
                ADDR_STATE:  rdata_q <= DATA_W'({sw, pulse_q, dir_q,
                                                 state_q});
                default:     rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata         = rdata_q;
    assign pulse_out         = pulse_q;
    assign direction_out     = dirout_q;
    assign abnormal_end_flag = abn_q;
    assign irq               = irq_q;
endmodule
`default_nettype wire

/* File: verification/jpt_checker.sv */
// concurrent checks on the ports of the jog pulse-train top
`timescale 1ns/1ps
`default_nettype none
module jpt_checker
    import jpt_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              fwd_limit_in,
    input wire logic              rev_limit_in,
    input wire logic              jog_fwd_in,
    input wire logic              jog_rev_in,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              pulse_out,
    input wire logic              direction_out,
    input wire logic              abnormal_end_flag,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] hold_q;
    logic       clr;
    assign clr = reg_wr && reg_addr == ADDR_STATUS && reg_wdata[EVT_ABN_BIT];
    // edges since pulse_out last moved; saturates so idle never wraps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) hold_q <= 8'h00;
        else if ($changed(pulse_out)) hold_q <= 8'h00;
        else if (hold_q != 8'hFF) hold_q <= hold_q + 8'h01;
    end
    a_stop_jog: assert property (
        !jog_fwd_in && !jog_rev_in |-> ##3 !pulse_out)
        else $error("pulse output high after jog release");
    a_stop_limit: assert property (
        !fwd_limit_in && pulse_out && direction_out |-> ##3 !pulse_out)
        else $error("forward limit did not stop the pulses");
    a_abn_set: assert property (
        !fwd_limit_in && pulse_out && direction_out
        |-> ##[1:3] abnormal_end_flag)
        else $error("limit stop without abnormal-end flag");
    a_flag_hold: assert property (
        abnormal_end_flag && !clr && !$past(clr) |=> abnormal_end_flag)
        else $error("abnormal-end flag dropped without a clear");
    // limit seen low one or two edges before the flag is seen high
    a_flag_cause: assert property (
        $rose(abnormal_end_flag) |-> !$past(fwd_limit_in)
        || !$past(rev_limit_in) || !$past(fwd_limit_in, 2)
        || !$past(rev_limit_in, 2))
        else $error("abnormal-end flag rose with no limit low");
    a_half_high: assert property (
        $fell(pulse_out) |-> hold_q <= 8'h63)
        else $error("pulse high phase longer than half period");
    a_half_low: assert property (
        $rose(pulse_out) |-> hold_q >= 8'h63)
        else $error("pulse low phase shorter than half period");
    a_rdata_zero: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside the answer cycle");
endmodule
bind jpt_top jpt_checker u_chk (.*);
`default_nettype wire

/* File: verification/jpt_drive_model.sv */
// behavioural motor drive that counts the steps it is sent
`timescale 1ns/1ps
`default_nettype none
module jpt_drive_model (
    input  wire logic clk,
    input  wire logic step_in,
    input  wire logic dir_in,
    input  wire logic sep_mode,
    output int        pos
);
    logic step_q = 1'b0;
    logic dir_q  = 1'b0;
    initial pos = 0;
    // sep mode: dir_in is the reverse train, so its rises step back
    always @(posedge clk) begin
        step_q <= step_in;
        dir_q  <= dir_in;
        if (step_in && !step_q)
            pos <= (sep_mode || dir_in) ? pos + 1 : pos - 1;
        if (sep_mode && dir_in && !dir_q) pos <= pos - 1;
    end
endmodule
`default_nettype wire

/* File: verification/jpt_top_tb.sv */
// self-checking bench for the jog pulse-train top
`timescale 1ns/1ps
`default_nettype none
module jpt_top_tb
    import jpt_pkg::*;
;
    logic              clk          = 1'b0;
    logic              rst_n        = 1'b0;
    logic              fwd_limit_in = 1'b1;
    logic              rev_limit_in = 1'b1;
    logic              jog_fwd_in   = 1'b0;
    logic              jog_rev_in   = 1'b0;
    logic [ADDR_W-1:0] reg_addr     = '0;
    logic [DATA_W-1:0] reg_wdata    = '0;
    logic              reg_wr       = 1'b0;
    logic              reg_rd       = 1'b0;
    logic              sep_mode     = 1'b0;
    logic              rd_d         = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              pulse_out;
    logic              direction_out;
    logic              abnormal_end_flag;
    logic              irq;
    logic [DATA_W-1:0] exp_q[$];
    int                pos;
    int                exp_pos      = 0;
    int                k;
    int                errors       = 0;
    int                total_checks = 0;

    jpt_top dut (.*);
    jpt_drive_model u_drive (.clk(clk), .step_in(pulse_out),
        .dir_in(direction_out), .sep_mode(sep_mode), .pos(pos));

    always #25 clk = ~clk;

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp_data(input logic [DATA_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, exp);
        cmp_data({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d) cmp_data(reg_rdata, exp_q.pop_front());
    end
    // hold jogs for m edges; mid-move check direction_out against d, or pulse_out for a separate-train reverse jog
    task automatic jog(input logic f, r, input int m, input logic d);
        @(posedge clk);
        jog_fwd_in <= f;
        jog_rev_in <= r;
        repeat (m / 2) @(posedge clk);
        @(negedge clk);
        cmp_bit(sep_mode && r ? pulse_out : direction_out, d);
        repeat (m - m / 2) @(posedge clk);
        jog_fwd_in <= 1'b0;
        jog_rev_in <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp_bit(pulse_out, 1'b0);
        cmp_data(pos, exp_pos);
    endtask
    // trip a limit just after the first pulse rises
    task automatic lim_stop(input logic f);
        int n;
        n = 0;
        @(posedge clk);
        jog_fwd_in <= f;
        jog_rev_in <= !f;
        while (pulse_out !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            errors++;
            report_and_stop();
        end
        fwd_limit_in <= !f;
        rev_limit_in <= f;
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp_bit(pulse_out, 1'b0);
        cmp_bit(abnormal_end_flag, 1'b1);
        @(posedge clk);
        jog_fwd_in <= 1'b0;
        jog_rev_in <= 1'b0;
        @(posedge clk);
        fwd_limit_in <= 1'b1;
        rev_limit_in <= 1'b1;
        @(negedge clk);
        cmp_data(pos, exp_pos);
    endtask

    initial begin
        void'($urandom(19));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_POS_LO, 32'h0);
        rd(8'h40, 32'h0);
        // lengths sit mid-period so the pulse count is exact
        k = $urandom % 4 + 1;
        exp_pos += k + 1;
        jog(1'b1, 1'b0, 200 * k + 150, 1'b1);
        rd(ADDR_STATUS, 32'h2);
        repeat (300) @(posedge clk);
        rd(ADDR_POS_LO, {16'h0, exp_pos[15:0]});
        rd(ADDR_POS_HI, 32'h0);
        @(negedge clk);
        cmp_bit(direction_out, 1'b1);
        wr(ADDR_CTRL, 32'h1);
        sep_mode <= 1'b1;
        k = $urandom % 4 + 1;
        exp_pos += k + 1;
        jog(1'b1, 1'b0, 200 * k + 150, 1'b0);
        exp_pos -= 2;
        jog(1'b0, 1'b1, 350, 1'b0);
        jog(1'b1, 1'b1, 300, 1'b0);
        fwd_limit_in <= 1'b0;
        jog(1'b1, 1'b0, 300, 1'b0);
        fwd_limit_in <= 1'b1;
        rd(ADDR_POS_LO, {16'h0, exp_pos[15:0]});
        wr(ADDR_CTRL, 32'h0);
        sep_mode <= 1'b0;
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_MASK, 32'h1);
        exp_pos += 1;
        lim_stop(1'b1);
        @(negedge clk);
        cmp_bit(irq, 1'b1);
        rd(ADDR_STATUS, 32'h3);
        wr(ADDR_STATUS, 32'h1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp_bit(abnormal_end_flag, 1'b0);
        cmp_bit(irq, 1'b0);
        exp_pos -= 1;
        lim_stop(1'b0);
        @(negedge clk);
        cmp_bit(direction_out, 1'b0);
        rd(ADDR_POS_LO, {16'h0, exp_pos[15:0]});
        // idle, direction latch low, both limits closed, no jog
        rd(ADDR_STATE, 32'h30);
        repeat (2) @(posedge clk);
        report_and_stop();
    end
endmodule
`default_nettype wire
